/* File: logic/blc_regs.sv */
// backlight control, dimming mix and fault/status register set
//
// Behaviour
// RL1: source select 1 lets the external dimming input drive PWM, ignoring interpretation.
// RL2: select 0, interpretation 1: PWM duty comes straight from programmed brightness.
// RL3: both 0: duty is brightness times external duty fraction, internal frequency.
// RL4: reserved control bits read zero and ignore writes.
// RL5: defined control bits read back their latched value.
// RL6: writing on bit 1 lights backlight within 4 ms; flag set, mask nonzero.
// RL7: writing on bit 0 turns backlight off at once; flag and mask read 0.
// RL8: SMBus mode reads last written brightness; external mode reads effective value.
// RL9: scaled mode reads back the last written brightness, not the product.
// RL10: entering SMBus mode keeps brightness; other modes change it to suit; code reloads it with the effective level when going from external to absolute.
// RL11: control register resets to 0x00: off, SMBus control, percentage mode.
// RL12: status bit 3 shows the backlight on flag.
// RL13: status bit 0 is OR of fault conditions; on flag never sets it.
// RL14: bit 4 means one or more channels down, bit 5 two or more.
// RL15: bit 2 shows input overcurrent, bit 1 thermal shutdown, live.
// RL16: summary fault is sticky; cleared by on toggle or write low; resets.
// RL17: an on command followed at once by off reports no fault.
// RL18: loss of backlight supply sets no fault indication.
// RL19: status resets to 0x00; only bit 0 writable (clear); reserved read 0.
// RL20: identification holds 1 in bit 7, maker code 6:3, revision 2:0.
// RL21: revision field starts at 0 and counts up per release.
// RL22: brightness register is 8-bit read/write, 256 duty steps.
// RL23: brightness writes take effect only in SMBus control; resets to 0xFF.
// RL24: channel readback shows 0 for disabled or faulted channels; re-enable retries.
`timescale 1ns/1ns
`default_nettype none
module blc_regs #(
	parameter int ON_CYC = blc_pkg::ON_CYC,
	parameter int SAMPLE_DIV = 1000,
	parameter int DIM_DIV = 8,
	// arbitrary neutral code
	parameter logic [3:0] MAKER_CODE = 4'h5,
	parameter logic [2:0] SILICON_REV = 3'h0
) (
	input wire logic i_clk,
	input wire logic i_rstn,
	input wire logic i_wr_stb,
	input wire logic i_rd_stb,
	input wire logic [7:0] i_addr,
	input wire logic [7:0] i_wdata,
	output logic [7:0] o_rdata,
	output logic o_rd_ack,
	input wire logic i_external_dimming_input,
	input wire blc_pkg::blc_fault_s i_faults,
	input wire logic [blc_pkg::NUM_CH-1:0] i_chan_mask,
	output logic o_pwm,
	output logic o_bl_enable,
	output logic [blc_pkg::NUM_CH-1:0] o_chan_readback
);

	localparam int ON_W = $clog2(ON_CYC + 1);

	function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
		hit = (a == off);
	endfunction : hit

	function automatic blc_pkg::blc_mode_e dim_mode(input blc_pkg::blc_ctrl_s c);
		if (c.sel) begin
			dim_mode = blc_pkg::BLC_MODE_EXT;
		end else if (c.md) begin
			dim_mode = blc_pkg::BLC_MODE_ABS;
		end else begin
			dim_mode = blc_pkg::BLC_MODE_SCALED;
		end
	endfunction : dim_mode

	function automatic logic two_or_more(input logic [blc_pkg::NUM_CH-1:0] v);
		logic [3:0] n;
		n = 4'h0;
		for (int k = 0; k < blc_pkg::NUM_CH; k++) begin
			n = n + {3'h0, v[k]};
		end
		two_or_more = (n > 4'h1);
	endfunction : two_or_more

	// pin synchronisers
	logic dim_s1_r;
	logic dim_s2_r;
	blc_pkg::blc_fault_s flt_s1_r;
	blc_pkg::blc_fault_s flt_s2_r;

	always_ff @(posedge i_clk or negedge i_rstn) begin
		if (!i_rstn) begin
			dim_s1_r <= 1'b0;
			dim_s2_r <= 1'b0;
			flt_s1_r <= '0;
			flt_s2_r <= '0;
		end else begin
			dim_s1_r <= i_external_dimming_input;
			dim_s2_r <= dim_s1_r;
			flt_s1_r <= i_faults;
			flt_s2_r <= flt_s1_r;
		end
	end

	blc_pkg::blc_ctrl_s ctrl_r;
	blc_pkg::blc_ctrl_s ctrl_nxt;
	logic [7:0] bright_r;
	logic [7:0] ext_duty_r;
	logic fault_r;
	blc_pkg::blc_state_e state_r;
	blc_pkg::blc_state_e state_nxt;
	logic [ON_W-1:0] on_cnt_r;

	logic wr_ctrl;
	logic wr_bright;
	logic wr_stat;
	logic on_toggle;
	blc_pkg::blc_mode_e mode_cur;
	blc_pkg::blc_mode_e mode_new;

	assign wr_ctrl = i_wr_stb && hit(i_addr, blc_pkg::REG_CTRL);
	assign wr_bright = i_wr_stb && hit(i_addr, blc_pkg::REG_BRIGHT);
	assign wr_stat = i_wr_stb && hit(i_addr, blc_pkg::REG_STAT);
	assign mode_cur = dim_mode(ctrl_r);
	assign mode_new = dim_mode(ctrl_nxt);
	assign on_toggle = wr_ctrl && (ctrl_nxt.on != ctrl_r.on);

	// RL4 reserved bits dropped
	always_comb begin
		ctrl_nxt = ctrl_r;
		if (wr_ctrl) begin
			ctrl_nxt.on = i_wdata[blc_pkg::CTRL_ON_BIT];
			ctrl_nxt.sel = i_wdata[blc_pkg::CTRL_SEL_BIT];
			ctrl_nxt.md = i_wdata[blc_pkg::CTRL_MD_BIT];
		end
	end

	// RL11 control reset value
	always_ff @(posedge i_clk or negedge i_rstn) begin
		if (!i_rstn) begin
			ctrl_r <= blc_pkg::CTRL_RST[2:0];
		end else begin
			ctrl_r <= ctrl_nxt;
		end
	end

	// external duty measured by sampling: one window is 255 samples,
	// so the count maps onto the 0..255 brightness scale without a divider
	logic [15:0] samp_cnt_r;
	logic [7:0] win_cnt_r;
	logic [7:0] high_cnt_r;
	logic samp_tick;

	assign samp_tick = (samp_cnt_r == 16'(SAMPLE_DIV - 1));

	always_ff @(posedge i_clk or negedge i_rstn) begin
		if (!i_rstn) begin
			samp_cnt_r <= 16'h0000;
		end else if (samp_tick) begin
			samp_cnt_r <= 16'h0000;
		end else begin
			samp_cnt_r <= samp_cnt_r + 16'h0001;
		end
	end

	always_ff @(posedge i_clk or negedge i_rstn) begin
		if (!i_rstn) begin
			win_cnt_r <= 8'h00;
			high_cnt_r <= 8'h00;
			ext_duty_r <= blc_pkg::DUTY_FULL;
		end else if (samp_tick) begin
			if (win_cnt_r == blc_pkg::STEPS_LAST) begin
				win_cnt_r <= 8'h00;
				high_cnt_r <= 8'h00;
				ext_duty_r <= high_cnt_r + {7'h00, dim_s2_r};
			end else begin
				win_cnt_r <= win_cnt_r + 8'h01;
				high_cnt_r <= high_cnt_r + {7'h00, dim_s2_r};
			end
		end
	end

	// RL22 full 8-bit brightness
	// RL23 writes only under SMBus control
	// RL10 leaving external for absolute mode loads the effective level
	always_ff @(posedge i_clk or negedge i_rstn) begin
		if (!i_rstn) begin
			bright_r <= blc_pkg::BRIGHT_RST;
		end else if (wr_bright && (mode_cur != blc_pkg::BLC_MODE_EXT)) begin
			bright_r <= i_wdata;
		end else if (wr_ctrl && (mode_cur == blc_pkg::BLC_MODE_EXT)
				&& (mode_new == blc_pkg::BLC_MODE_ABS)) begin
			bright_r <= ext_duty_r;
		end
	end

	// RL3 product rounded so full times full stays full
	logic [15:0] prod;
	logic [7:0] scaled;
	logic [7:0] duty;

	assign prod = 16'(bright_r) * 16'(ext_duty_r) + 16'(bright_r);
	assign scaled = prod[15:8];

	// RL2 absolute duty
	always_comb begin
		case (mode_cur)
			blc_pkg::BLC_MODE_ABS: duty = bright_r;
			blc_pkg::BLC_MODE_SCALED: duty = scaled;
			default: duty = ext_duty_r;
		endcase
	end

	// internal dimming ramp, period of 255 steps
	logic [15:0] div_cnt_r;
	logic [7:0] ramp_r;
	logic div_tick;

	assign div_tick = (div_cnt_r == 16'(DIM_DIV - 1));

	always_ff @(posedge i_clk or negedge i_rstn) begin
		if (!i_rstn) begin
			div_cnt_r <= 16'h0000;
			ramp_r <= 8'h00;
		end else if (div_tick) begin
			div_cnt_r <= 16'h0000;
			if (ramp_r == blc_pkg::STEPS_LAST) begin
				ramp_r <= 8'h00;
			end else begin
				ramp_r <= ramp_r + 8'h01;
			end
		end else begin
			div_cnt_r <= div_cnt_r + 16'h0001;
		end
	end

	// on sequencing
	logic on_done;
	assign on_done = (on_cnt_r == ON_W'(ON_CYC - 1));

	// RL6 lit after the turn-on count
	// RL7 off straight from the write
	always_comb begin
		state_nxt = state_r;
		case (state_r)
			blc_pkg::BLC_ST_OFF: begin
				if (ctrl_nxt.on) begin
					state_nxt = blc_pkg::BLC_ST_RAMP;
				end
			end
			blc_pkg::BLC_ST_RAMP: begin
				if (!ctrl_nxt.on) begin
					state_nxt = blc_pkg::BLC_ST_OFF;
				end else if (on_done) begin
					state_nxt = blc_pkg::BLC_ST_LIT;
				end
			end
			blc_pkg::BLC_ST_LIT: begin
				if (!ctrl_nxt.on) begin
					state_nxt = blc_pkg::BLC_ST_OFF;
				end
			end
			default: state_nxt = blc_pkg::BLC_ST_OFF;
		endcase
	end

	always_ff @(posedge i_clk or negedge i_rstn) begin
		if (!i_rstn) begin
			state_r <= blc_pkg::BLC_ST_OFF;
			on_cnt_r <= '0;
		end else begin
			state_r <= state_nxt;
			if (state_nxt == blc_pkg::BLC_ST_RAMP) begin
				on_cnt_r <= on_cnt_r + ON_W'(1);
			end else begin
				on_cnt_r <= '0;
			end
		end
	end

	logic lit;
	logic lit_nxt;
	assign lit = (state_r == blc_pkg::BLC_ST_LIT);
	assign lit_nxt = (state_nxt == blc_pkg::BLC_ST_LIT);

	// RL1 external input drives output directly
	always_ff @(posedge i_clk or negedge i_rstn) begin
		if (!i_rstn) begin
			o_pwm <= 1'b0;
			o_bl_enable <= 1'b0;
		end else begin
			o_bl_enable <= lit_nxt;
			if (!lit_nxt) begin
				o_pwm <= 1'b0;
			end else if (mode_new == blc_pkg::BLC_MODE_EXT) begin
				o_pwm <= dim_s2_r;
			end else begin
				o_pwm <= (ramp_r < duty) || (duty == blc_pkg::DUTY_FULL);
			end
		end
	end

	// fault conditions, all dropped while the supply is absent
	logic therm_live;
	logic ovc_live;
	logic one_live;
	logic two_live;
	logic [blc_pkg::NUM_CH-1:0] chan_live;

	// RL18 supply loss masks faults
	// RL17 channel faults only once lit
	assign chan_live = (flt_s2_r.supply_ok && lit) ? flt_s2_r.chan : '0;
	// RL15 live overcurrent and thermal
	assign therm_live = flt_s2_r.supply_ok && flt_s2_r.thermal;
	assign ovc_live = flt_s2_r.supply_ok && flt_s2_r.overcurrent;
	// RL14 one or two channels down
	assign one_live = |chan_live;
	assign two_live = two_or_more(chan_live);

	// RL13 summary OR without on flag
	// RL16 sticky, set beats clear
	always_ff @(posedge i_clk or negedge i_rstn) begin
		if (!i_rstn) begin
			fault_r <= blc_pkg::STAT_RST[blc_pkg::ST_FAULT_BIT];
		end else if (therm_live || ovc_live || one_live || two_live) begin
			fault_r <= 1'b1;
		end else if (on_toggle || (wr_stat && !i_wdata[blc_pkg::ST_FAULT_BIT])) begin
			fault_r <= 1'b0;
		end
	end

	// RL24 disabled or faulted channels read 0
	// RL7 mask reads 0 while off
	always_ff @(posedge i_clk or negedge i_rstn) begin
		if (!i_rstn) begin
			o_chan_readback <= '0;
		end else if (lit_nxt) begin
			o_chan_readback <= i_chan_mask & ~chan_live;
		end else begin
			o_chan_readback <= '0;
		end
	end

	// status view
	logic [7:0] stat_view;
	// RL19 reserved status bits zero
	// RL12 on flag in bit 3
	always_comb begin
		stat_view = blc_pkg::STAT_RST;
		stat_view[blc_pkg::ST_FAULT_BIT] = fault_r;
		stat_view[blc_pkg::ST_THERM_BIT] = therm_live;
		stat_view[blc_pkg::ST_OVC_BIT] = ovc_live;
		stat_view[blc_pkg::ST_ON_BIT] = lit;
		stat_view[blc_pkg::ST_ONE_BIT] = one_live;
		stat_view[blc_pkg::ST_TWO_BIT] = two_live;
	end

	logic [7:0] ctrl_view;
	// RL5 latched control bits read back
	always_comb begin
		ctrl_view = blc_pkg::CTRL_RST;
		ctrl_view[blc_pkg::CTRL_ON_BIT] = ctrl_r.on;
		ctrl_view[blc_pkg::CTRL_SEL_BIT] = ctrl_r.sel;
		ctrl_view[blc_pkg::CTRL_MD_BIT] = ctrl_r.md;
	end

	logic [7:0] rd_mux;
	always_comb begin
		if (hit(i_addr, blc_pkg::REG_BRIGHT)) begin
			// RL8 external mode shows effective level
			// RL9 scaled mode shows written value
			if (mode_cur == blc_pkg::BLC_MODE_EXT) begin
				rd_mux = ext_duty_r;
			end else begin
				rd_mux = bright_r;
			end
		end else if (hit(i_addr, blc_pkg::REG_CTRL)) begin
			rd_mux = ctrl_view;
		end else if (hit(i_addr, blc_pkg::REG_STAT)) begin
			rd_mux = stat_view;
		end else if (hit(i_addr, blc_pkg::REG_ID)) begin
			// RL20 fixed identification layout
			// RL21 revision from parameter
			rd_mux = {blc_pkg::ID_PANEL, MAKER_CODE, SILICON_REV};
		end else begin
			rd_mux = blc_pkg::RDATA_NONE;
		end
	end

	always_ff @(posedge i_clk or negedge i_rstn) begin
		if (!i_rstn) begin
			o_rdata <= blc_pkg::RDATA_NONE;
			o_rd_ack <= 1'b0;
		end else begin
			o_rd_ack <= i_rd_stb;
			if (i_rd_stb) begin
				o_rdata <= rd_mux;
			end
		end
	end

endmodule : blc_regs
`default_nettype wire

/* File: logic/blc_pkg.sv */
// constants and carrier types for the backlight control and status registers
`default_nettype none
package blc_pkg;
	// register offsets
	localparam logic [7:0] REG_BRIGHT = 8'h00;
	localparam logic [7:0] REG_CTRL = 8'h01;
	localparam logic [7:0] REG_STAT = 8'h02;
	localparam logic [7:0] REG_ID = 8'h03;
	// reset values
	localparam logic [7:0] BRIGHT_RST = 8'hFF;
	localparam logic [7:0] CTRL_RST = 8'h00;
	localparam logic [7:0] STAT_RST = 8'h00;
	localparam logic [7:0] RDATA_NONE = 8'h00;
	// control bit positions
	localparam int CTRL_ON_BIT = 0;
	localparam int CTRL_SEL_BIT = 1;
	localparam int CTRL_MD_BIT = 2;
	// status bit positions
	localparam int ST_FAULT_BIT = 0;
	localparam int ST_THERM_BIT = 1;
	localparam int ST_OVC_BIT = 2;
	localparam int ST_ON_BIT = 3;
	localparam int ST_ONE_BIT = 4;
	localparam int ST_TWO_BIT = 5;
	// identification layout
	localparam logic ID_PANEL = 1'b1;
	// brightness scale
	localparam logic [7:0] DUTY_FULL = 8'hFF;
	localparam logic [7:0] STEPS_LAST = 8'hFE;
	// turn-on time
	localparam int CLK_HZ = 50_000_000;
	localparam int ON_TIME_US = 4000;
	localparam int ON_CYC = ON_TIME_US * (CLK_HZ / 1_000_000);
	localparam int NUM_CH = 8;
	typedef enum logic [1:0] {
		BLC_MODE_EXT = 2'b00,
		BLC_MODE_ABS = 2'b01,
		BLC_MODE_SCALED = 2'b10
	} blc_mode_e;
	typedef enum logic [1:0] {
		BLC_ST_OFF = 2'b00,
		BLC_ST_RAMP = 2'b01,
		BLC_ST_LIT = 2'b10
	} blc_state_e;
	typedef struct packed {
		logic md;
		logic sel;
		logic on;
	} blc_ctrl_s;
	typedef struct packed {
		logic supply_ok;
		logic thermal;
		logic overcurrent;
		logic [NUM_CH-1:0] chan;
	} blc_fault_s;
endpackage : blc_pkg
`default_nettype wire

/* File: sim/blc_host.sv */
// host model issuing byte read and write strobes
`timescale 1ns/1ns
`default_nettype none
module blc_host (
	input wire logic i_clk,
	input wire logic i_rd_ack,
	input wire logic [7:0] i_rdata,
	output logic o_wr_stb,
	output logic o_rd_stb,
	output logic [7:0] o_addr,
	output logic [7:0] o_wdata
);
	initial begin
		o_wr_stb = 1'b0;
		o_rd_stb = 1'b0;
		o_addr = 8'h00;
		o_wdata = 8'h00;
	end
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge i_clk);
		o_wr_stb <= 1'b1;
		o_addr <= a;
		o_wdata <= d;
		@(posedge i_clk);
		o_wr_stb <= 1'b0;
		// released lines show a stale-proof value, not the last byte
		o_addr <= ~a;
		o_wdata <= ~d;
	endtask : wr
	task automatic rd(input logic [7:0] a, output logic [7:0] d, output logic ok);
		@(posedge i_clk);
		o_rd_stb <= 1'b1;
		o_addr <= a;
		@(posedge i_clk);
		o_rd_stb <= 1'b0;
		o_addr <= ~a;
		// registered answer: taken at the edge where the ack is sampled high
		@(posedge i_clk);
		ok = i_rd_ack;
		d = i_rdata;
	endtask : rd
endmodule : blc_host
`default_nettype wire

/* File: sim/blc_regs_chk.sv */
// port assertions for the register set
`timescale 1ns/1ns
`default_nettype none
module blc_regs_chk (
	input wire logic i_clk,
	input wire logic i_rstn,
	input wire logic i_wr_stb,
	input wire logic i_rd_stb,
	input wire logic [7:0] i_addr,
	input wire logic [7:0] i_wdata,
	input wire logic [7:0] o_rdata,
	input wire logic o_rd_ack,
	input wire logic o_bl_enable,
	input wire logic [blc_pkg::NUM_CH-1:0] o_chan_readback
);
	default clocking @(posedge i_clk); endclocking
	default disable iff (!i_rstn);
	sequence rd_s(logic [7:0] a);
		i_rd_stb && i_addr == a;
	endsequence
	sequence off_s;
		i_wr_stb && i_addr == 8'h01 && !i_wdata[0];
	endsequence
	ack_follow_a: assert property (i_rd_stb |=> o_rd_ack)
		else $error("read ack missing");
	ack_once_a: assert property (!i_rd_stb |=> !o_rd_ack)
		else $error("stray read ack");
	ctrl_rsv_a: assert property (rd_s(8'h01) |=> o_rdata[7:3] == 5'h00)
		else $error("control reserved bits set");
	stat_rsv_a: assert property (rd_s(8'h02) |=> o_rdata[7:6] == 2'h0)
		else $error("status reserved bits set");
	id_mark_a: assert property (rd_s(8'h03) |=> o_rdata[7])
		else $error("id top bit clear");
	off_now_a: assert property (off_s |=> ##1 !o_bl_enable && o_chan_readback == '0)
		else $error("backlight not off");
	on_flag_a: assert property (rd_s(8'h02) ##0 (o_bl_enable && !i_wr_stb) |=> o_rdata[3])
		else $error("on flag not shown");
	dark_chan_a: assert property (!o_bl_enable && !$past(o_bl_enable) |-> o_chan_readback == '0)
		else $error("channels shown while dark");
endmodule : blc_regs_chk
bind blc_regs blc_regs_chk chk_u (.i_clk(i_clk), .i_rstn(i_rstn), .i_wr_stb(i_wr_stb),
	.i_rd_stb(i_rd_stb), .i_addr(i_addr), .i_wdata(i_wdata), .o_rdata(o_rdata),
	.o_rd_ack(o_rd_ack), .o_bl_enable(o_bl_enable), .o_chan_readback(o_chan_readback));
`default_nettype wire

/* File: sim/tb_blc_regs.sv */
// self-checking bench for the register set
`timescale 1ns/1ns
`default_nettype none
module tb_blc_regs;
	logic clk, rstn, wr_stb, rd_stb, ext, rd_ack, pwm, bl_en;
	logic [7:0] addr, wdata, rdata, mask, chan_rb;
	blc_pkg::blc_fault_s flt;
	int bad_count = 0;
	int cmp_count = 0;
	blc_regs #(.ON_CYC(20), .SAMPLE_DIV(2), .DIM_DIV(1)) dut_u (.i_clk(clk), .i_rstn(rstn),
		.i_wr_stb(wr_stb), .i_rd_stb(rd_stb), .i_addr(addr), .i_wdata(wdata),
		.o_rdata(rdata), .o_rd_ack(rd_ack), .i_external_dimming_input(ext),
		.i_faults(flt), .i_chan_mask(mask), .o_pwm(pwm), .o_bl_enable(bl_en),
		.o_chan_readback(chan_rb));
	blc_host host_u (.i_clk(clk), .i_rd_ack(rd_ack), .i_rdata(rdata), .o_wr_stb(wr_stb),
		.o_rd_stb(rd_stb), .o_addr(addr), .o_wdata(wdata));
	task automatic stop_test();
		$display("checks %0d mismatches %0d", cmp_count, bad_count);
		if (bad_count == 0 && cmp_count > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask : stop_test
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		cmp_count++;
		if (got !== exp) begin
			bad_count++;
			$display("unexpected at %0t: got %h want %h", $time, got, exp);
		end
	endtask : chk
	task automatic rdc(input logic [7:0] a, input logic [7:0] e);
		logic [7:0] d;
		logic ok;
		host_u.rd(a, d, ok);
		chk({7'h00, ok}, 8'h01);
		chk(d, e);
	endtask : rdc
	task automatic cnt(input int n, output int k);
		k = 0;
		repeat (n) begin
			@(posedge clk);
			#1;
			if (pwm === 1'b1) k++;
		end
	endtask : cnt
	// fault word: supply_ok, thermal, overcurrent, then channels 7..0
	task automatic setf(input logic [10:0] f);
		@(posedge clk);
		flt <= f;
		repeat (6) @(posedge clk);
	endtask : setf
	task automatic on_wait();
		int i;
		for (i = 0; i < 24 && bl_en !== 1'b1; i++) @(posedge clk);
		#1;
		chk({7'h00, bl_en}, 8'h01);
		if (i == 24) stop_test();
	endtask : on_wait
	task automatic t_reset();
		rdc(8'h00, 8'hFF);
		rdc(8'h01, 8'h00);
		rdc(8'h02, 8'h00);
		// maker code is the design's arbitrary default
		rdc(8'h03, {1'b1, 4'h5, 3'h0});
		host_u.wr(8'h03, 8'h00);
		host_u.wr(8'h02, 8'hFF);
		rdc(8'h03, {1'b1, 4'h5, 3'h0});
		rdc(8'h02, 8'h00);
		rdc(8'h04, 8'h00);
		$display("reset test over");
	endtask : t_reset
	task automatic t_modes();
		host_u.wr(8'h01, 8'hFC);
		rdc(8'h01, 8'h04);
		host_u.wr(8'h00, 8'h5A);
		rdc(8'h00, 8'h5A);
		host_u.wr(8'h01, 8'h06);
		rdc(8'h01, 8'h06);
		rdc(8'h00, 8'hFF);
		host_u.wr(8'h00, 8'h11);
		rdc(8'h00, 8'hFF);
		// leaving external mode for scaled mode keeps the stored level
		host_u.wr(8'h01, 8'h00);
		rdc(8'h00, 8'h5A);
		host_u.wr(8'h01, 8'h06);
		host_u.wr(8'h01, 8'h04);
		rdc(8'h00, 8'hFF);
		host_u.wr(8'h01, 8'h00);
		host_u.wr(8'h00, 8'h33);
		rdc(8'h00, 8'h33);
		$display("mode test over");
	endtask : t_modes
	task automatic t_pwm();
		int k;
		// the output only dims while lit, so the backlight is switched on first
		host_u.wr(8'h01, 8'h05);
		host_u.wr(8'h00, 8'h80);
		on_wait();
		repeat (10) @(posedge clk);
		cnt(255, k);
		chk(8'(k), 8'h80);
		host_u.wr(8'h01, 8'h01);
		repeat (10) @(posedge clk);
		cnt(255, k);
		chk(8'(k), 8'h80);
		@(posedge clk);
		ext <= 1'b0;
		repeat (1200) @(posedge clk);
		cnt(255, k);
		chk(8'(k), 8'h00);
		rdc(8'h00, 8'h80);
		host_u.wr(8'h01, 8'h03);
		repeat (8) @(posedge clk);
		chk({7'h00, pwm}, 8'h00);
		ext <= 1'b1;
		repeat (8) @(posedge clk);
		chk({7'h00, pwm}, 8'h01);
		host_u.wr(8'h01, 8'h04);
		@(posedge clk);
		#1;
		chk({7'h00, pwm}, 8'h00);
		$display("dimming test over");
	endtask : t_pwm
	task automatic t_onoff();
		host_u.wr(8'h01, 8'h05);
		on_wait();
		chk(chan_rb, 8'hFF);
		rdc(8'h02, 8'h08);
		host_u.wr(8'h01, 8'h04);
		@(posedge clk);
		#1;
		chk({7'h00, bl_en}, 8'h00);
		chk(chan_rb, 8'h00);
		rdc(8'h02, 8'h00);
		$display("on off test over");
	endtask : t_onoff
	task automatic t_fault();
		setf(11'h600);
		rdc(8'h02, 8'h03);
		setf(11'h400);
		rdc(8'h02, 8'h01);
		host_u.wr(8'h02, 8'h00);
		rdc(8'h02, 8'h00);
		setf(11'h500);
		rdc(8'h02, 8'h05);
		setf(11'h400);
		host_u.wr(8'h01, 8'h05);
		on_wait();
		rdc(8'h02, 8'h08);
		setf(11'h401);
		rdc(8'h02, 8'h19);
		chk(chan_rb, 8'hFE);
		setf(11'h403);
		rdc(8'h02, 8'h39);
		setf(11'h400);
		host_u.wr(8'h01, 8'h04);
		setf(11'h200);
		rdc(8'h02, 8'h00);
		setf(11'h4FF);
		host_u.wr(8'h01, 8'h05);
		host_u.wr(8'h01, 8'h04);
		repeat (6) @(posedge clk);
		rdc(8'h02, 8'h00);
		$display("fault test over");
	endtask : t_fault
	initial begin
		clk = 1'b0;
		forever #10 clk = ~clk;
	end
	initial begin
		#1_000_000;
		bad_count++;
		stop_test();
	end
	initial begin
		rstn = 1'b0;
		ext = 1'b1;
		mask = 8'hFF;
		flt = 11'h400;
		repeat (3) @(posedge clk);
		rstn <= 1'b1;
		t_reset();
		t_modes();
		t_pwm();
		t_onoff();
		t_fault();
		stop_test();
	end
endmodule : tb_blc_regs
`default_nettype wire
